// >>> isb_backptr.v
// Split isochronous IN back-pointer completion engine
`timescale 1ns/1ns
`include "isb_map.vh"
module isb_backptr (
    input  wire         I_REF_CLK,
    input  wire         I_SYS_RST,
    input  wire [7:0]   I_REG_ADDR,
    input  wire [31:0]  I_REG_WDATA,
    input  wire         I_REG_WR,
    input  wire         I_REG_RD,
    output reg  [31:0]  O_REG_RDATA,
    input  wire [2:0]   I_FRINDEX,
    input  wire         I_VISIT_VLD,
    input  wire [31:0]  I_VISIT_ADDR,
    output wire         O_VISIT_RDY,
    output reg          O_VISIT_DONE,
    output reg  [31:0]  O_NEXT_PTR,
    output reg          O_MEM_RD,
    output reg          O_MEM_WR,
    output reg  [31:0]  O_MEM_ADDR,
    input  wire         I_MEM_RVLD,
    input  wire [127:0] I_MEM_RDATA,
    output reg  [127:0] O_MEM_WDATA,
    output reg          O_SPLIT_REQ,
    output reg          O_SPLIT_CS,
    output reg  [31:0]  O_SPLIT_DESC,
    input  wire         I_SPLIT_DONE,
    input  wire [2:0]   I_SPLIT_RESP,
    input  wire [7:0]   I_SPLIT_BYTES
);

    // ==========================================================
    // States
    localparam [9:0] S_IDLE = 10'h001;
    localparam [9:0] S_FCUR = 10'h002;
    localparam [9:0] S_ECUR = 10'h004;
    localparam [9:0] S_FPRV = 10'h008;
    localparam [9:0] S_EPRV = 10'h010;
    localparam [9:0] S_CSW  = 10'h020;
    localparam [9:0] S_SSW  = 10'h040;
    localparam [9:0] S_WBP  = 10'h080;
    localparam [9:0] S_WBC  = 10'h100;
    localparam [9:0] S_DONE = 10'h200;

    reg [9:0]   state_r;
    reg [127:0] cur_r;          // Held whole while borrowing
    reg [127:0] prv_r;
    reg [31:0]  cur_addr_r;
    reg         in_prev_r;      // Split context belongs to previous
    reg [1:0]   retry_r;
    reg         retired_vld_r;
    reg [31:0]  retired_addr_r;
    reg [2:0]   fr_last_r;
    reg         ctrl_en_r;
    reg [15:0]  borrow_cnt_r;

    // ==========================================================
    // Functions
    // Micro-frame index to onehot, bit 0 is micro-frame 0
    function [7:0] uf_dec;
        input [2:0] idx;
        begin
            uf_dec = 8'h01 << idx;
        end
    endfunction

    // Slots that must already be in the progress mask; wraps to 6,7
    function [7:0] prior_mask;
        input [7:0] uf;
        begin
            prior_mask = (uf - 8'h01) | ((uf[0] | uf[1]) ? 8'hC0 : 8'h00);
        end
    endfunction

    // Test B against the complete mask
    function test_b;
        input [127:0] d;
        input [7:0]   uf;
        begin
            test_b = ((d[`ISB_F_CMASK] & prior_mask(uf) & ~d[`ISB_F_CPROG]) == 8'h00);
        end
    endfunction

    // Advance byte count, offset and page by received bytes
    function [127:0] advance;
        input [127:0] d;
        input [7:0]   n;
        reg   [12:0]  sum;
        begin
            advance = d;
            sum = {1'b0, d[`ISB_F_OFFSET]} + {5'h00, n};
            if ({2'h0, n} > d[`ISB_F_TOTAL]) begin
                // Too much data: nothing stored, babble and retire
                advance[`ISB_B_BABBLE] = 1'b1;
                advance[`ISB_B_ACTIVE] = 1'b0;
            end else begin
                advance[`ISB_F_TOTAL]  = d[`ISB_F_TOTAL] - {2'h0, n};
                advance[`ISB_F_OFFSET] = sum[11:0];
                if (sum[12]) begin
                    advance[`ISB_B_PAGE] = 1'b1;
                end
            end
        end
    endfunction

    // Apply a complete-split answer; progress mask already holds this slot
    function [127:0] cs_apply;
        input [127:0] d;
        input [2:0]   rsp;
        input [7:0]   n;
        input         retry_out;
        reg           last;
        begin
            cs_apply = d;
            last = ((d[`ISB_F_CMASK] ^ d[`ISB_F_CPROG]) == 8'h00);
            case (rsp)
                `ISB_RSP_ERR: begin
                    cs_apply[`ISB_B_ERR]    = 1'b1;
                    cs_apply[`ISB_B_ACTIVE] = 1'b0;
                end
                `ISB_RSP_XERR: begin
                    cs_apply[`ISB_B_XERR] = 1'b1;
                    if (retry_out) begin
                        cs_apply[`ISB_B_ACTIVE] = 1'b0;
                    end
                end
                `ISB_RSP_DATA: begin
                    cs_apply = advance(d, n);
                    cs_apply[`ISB_B_ACTIVE] = 1'b0;
                    cs_apply[`ISB_B_PHASE]  = `ISB_PH_SS;
                end
                `ISB_RSP_NYET: begin
                    if (last) begin
                        cs_apply[`ISB_B_ACTIVE] = 1'b0;
                    end
                end
                `ISB_RSP_MDAT: begin
                    if (last) begin
                        cs_apply[`ISB_B_XERR]   = 1'b1;
                        cs_apply[`ISB_B_ACTIVE] = 1'b0;
                    end else begin
                        cs_apply = advance(d, n); // Active kept unless advance flags babble
                    end
                end
                default: begin
                    cs_apply[`ISB_B_XERR]   = 1'b1;
                    cs_apply[`ISB_B_ACTIVE] = 1'b0;
                end
            endcase
        end
    endfunction

    // ==========================================================
    // Decode of current conditions
    wire [7:0]   uf       = uf_dec(I_FRINDEX);
    wire         cur_cs   = cur_r[`ISB_B_ACTIVE] && (cur_r[`ISB_B_PHASE] == `ISB_PH_CS);
    // Terminate bit is trusted as software sets it for non-wrap streams
    wire         borrow_a = (uf == 8'h01) && !cur_r[`ISB_B_BACKT];
    // Second wrap slot borrows only when the start mask skips micro-frame 0
    wire         borrow_b = (uf == 8'h02) && !cur_r[64];
    wire         retired  = retired_vld_r && (retired_addr_r == {cur_r[63:33], 1'b0});
    wire         borrow   = ctrl_en_r && cur_cs && (borrow_a || borrow_b) && !retired;
    wire         ss_now   = (uf == 8'h01) && cur_r[64];
    wire         rsp_x    = I_SPLIT_RESP == `ISB_RSP_XERR;

    // One visit accepted at a time, the walker steps per micro-frame
    assign O_VISIT_RDY = state_r[0];

    // ==========================================================
    // Main sequencer; pulses default low each cycle
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            state_r        <= S_IDLE;
            cur_r          <= 128'h0;
            prv_r          <= 128'h0;
            cur_addr_r     <= 32'h0;
            in_prev_r      <= 1'b0;
            retry_r        <= 2'h0;
            retired_vld_r  <= 1'b0;
            retired_addr_r <= 32'h0;
            fr_last_r      <= 3'h0;
            borrow_cnt_r   <= 16'h0;
            O_VISIT_DONE   <= 1'b0;
            O_NEXT_PTR     <= 32'h0;
            O_MEM_RD       <= 1'b0;
            O_MEM_WR       <= 1'b0;
            O_MEM_ADDR     <= 32'h0;
            O_MEM_WDATA    <= 128'h0;
            O_SPLIT_REQ    <= 1'b0;
            O_SPLIT_CS     <= 1'b0;
            O_SPLIT_DESC   <= 32'h0;
        end else begin
            O_VISIT_DONE <= 1'b0;
            O_MEM_RD     <= 1'b0;
            O_MEM_WR     <= 1'b0;
            O_SPLIT_REQ  <= 1'b0;
            fr_last_r    <= I_FRINDEX;
            // Retirement memory lasts one frame
            if (fr_last_r == 3'h7 && I_FRINDEX == 3'h0) begin
                retired_vld_r <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    if (I_VISIT_VLD) begin
                        cur_addr_r <= I_VISIT_ADDR;
                        O_MEM_ADDR <= I_VISIT_ADDR;
                        O_MEM_RD   <= 1'b1;
                        in_prev_r  <= 1'b0;
                        state_r    <= S_FCUR;
                    end
                end
                S_FCUR: begin
                    if (I_MEM_RVLD) begin
                        cur_r   <= I_MEM_RDATA;
                        state_r <= S_ECUR;
                    end
                end
                S_ECUR: begin
                    if (!cur_r[`ISB_B_ACTIVE]) begin
                        state_r <= S_DONE;
                    end else if (cur_r[`ISB_B_PHASE] == `ISB_PH_SS) begin
                        // Complete mask ignored in start phase
                        if ((uf & cur_r[`ISB_F_SMASK]) != 8'h00) begin
                            O_SPLIT_REQ  <= 1'b1;
                            O_SPLIT_CS   <= 1'b0;
                            O_SPLIT_DESC <= cur_addr_r;
                            state_r      <= S_SSW;
                        end else begin
                            state_r <= S_DONE;
                        end
                    end else if (borrow) begin
                        // Only the current descriptor may borrow
                        O_MEM_ADDR   <= {cur_r[63:33], 1'b0};
                        O_MEM_RD     <= 1'b1;
                        borrow_cnt_r <= borrow_cnt_r + 16'h0001;
                        state_r      <= S_FPRV;
                    end else if ((uf & cur_r[`ISB_F_CMASK]) != 8'h00) begin
                        if (test_b(cur_r, uf)) begin
                            cur_r[`ISB_F_CPROG] <= cur_r[`ISB_F_CPROG] | uf;
                            retry_r      <= 2'h0;
                            O_SPLIT_REQ  <= 1'b1;
                            O_SPLIT_CS   <= 1'b1;
                            O_SPLIT_DESC <= cur_addr_r;
                            state_r      <= S_CSW;
                        end else begin
                            cur_r[`ISB_B_MISSED] <= 1'b1;
                            cur_r[`ISB_B_ACTIVE] <= 1'b0;
                            state_r              <= S_WBC;
                        end
                    end else begin
                        state_r <= S_DONE;
                    end
                end
                S_FPRV: begin
                    if (I_MEM_RVLD) begin
                        prv_r     <= I_MEM_RDATA; // cur_r untouched
                        in_prev_r <= 1'b1;
                        state_r   <= S_EPRV;
                    end
                end
                S_EPRV: begin
                    if (!prv_r[`ISB_B_ACTIVE]) begin
                        state_r <= S_WBP;
                    end else if (prv_r[`ISB_B_PHASE] == `ISB_PH_SS) begin
                        prv_r[`ISB_B_ACTIVE] <= 1'b0;
                        prv_r[`ISB_B_MISSED] <= 1'b1;
                        state_r              <= S_WBP;
                    end else if ((uf & prv_r[`ISB_F_CMASK]) != 8'h00) begin
                        if (test_b(prv_r, uf)) begin
                            prv_r[`ISB_F_CPROG] <= prv_r[`ISB_F_CPROG] | uf;
                            retry_r      <= 2'h0;
                            O_SPLIT_REQ  <= 1'b1;
                            O_SPLIT_CS   <= 1'b1;
                            O_SPLIT_DESC <= {cur_r[63:33], 1'b0};
                            state_r      <= S_CSW;
                        end else begin
                            prv_r[`ISB_B_MISSED] <= 1'b1;
                            prv_r[`ISB_B_ACTIVE] <= 1'b0;
                            state_r              <= S_WBP;
                        end
                    end else begin
                        state_r <= S_WBP;
                    end
                end
                S_CSW: begin
                    if (I_SPLIT_DONE) begin
                        if (rsp_x && retry_r != `ISB_MAX_RETRY) begin
                            // Transaction error retried at once, two retries at most
                            retry_r     <= retry_r + 2'h1;
                            O_SPLIT_REQ <= 1'b1;
                        end else if (in_prev_r) begin
                            prv_r   <= cs_apply(prv_r, I_SPLIT_RESP, I_SPLIT_BYTES, rsp_x);
                            state_r <= S_WBP;
                        end else begin
                            cur_r   <= cs_apply(cur_r, I_SPLIT_RESP, I_SPLIT_BYTES, rsp_x);
                            state_r <= S_WBC;
                        end
                    end
                end
                S_SSW: begin
                    if (I_SPLIT_DONE) begin
                        // IN start-split: progress restarts, position/count untouched
                        cur_r[`ISB_B_PHASE] <= `ISB_PH_CS;
                        cur_r[`ISB_F_CPROG] <= 8'h00;
                        state_r             <= S_WBC;
                    end
                end
                S_WBP: begin
                    O_MEM_ADDR  <= {cur_r[63:33], 1'b0};
                    O_MEM_WDATA <= prv_r;
                    O_MEM_WR    <= 1'b1;
                    in_prev_r   <= 1'b0;
                    if (prv_r[`ISB_B_ACTIVE]) begin
                        state_r <= S_DONE; // Current left as is
                    end else begin
                        retired_vld_r       <= 1'b1;
                        retired_addr_r      <= {cur_r[63:33], 1'b0};
                        cur_r[`ISB_B_PHASE] <= `ISB_PH_SS;
                        if (ss_now) begin
                            O_SPLIT_REQ  <= 1'b1;
                            O_SPLIT_CS   <= 1'b0;
                            O_SPLIT_DESC <= cur_addr_r;
                            state_r      <= S_SSW;
                        end else begin
                            state_r <= S_WBC;
                        end
                    end
                end
                S_WBC: begin
                    O_MEM_ADDR  <= cur_addr_r;
                    O_MEM_WDATA <= cur_r;
                    O_MEM_WR    <= 1'b1;
                    state_r     <= S_DONE;
                end
                S_DONE: begin
                    O_NEXT_PTR   <= cur_r[`ISB_F_NEXT];
                    O_VISIT_DONE <= 1'b1;
                    state_r      <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Register port; read data stands one cycle after the strobe
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            ctrl_en_r   <= `ISB_CTRL_RST;
            O_REG_RDATA <= 32'h0;
        end else begin
            if (I_REG_WR && I_REG_ADDR == `ISB_REG_CTRL) begin
                ctrl_en_r <= I_REG_WDATA[0];
            end
            if (I_REG_RD) begin
                case (I_REG_ADDR)
                    `ISB_REG_CTRL:   O_REG_RDATA <= {31'h0, ctrl_en_r};
                    `ISB_REG_STATE:  O_REG_RDATA <= {20'h0, in_prev_r, retired_vld_r, state_r};
                    `ISB_REG_BORROW: O_REG_RDATA <= {16'h0, borrow_cnt_r};
                    default:         O_REG_RDATA <= 32'h0;
                endcase
            end else begin
                O_REG_RDATA <= 32'h0;
            end
        end
    end

endmodule

// >>> isb_backptr_asserts.sv
// Port-level checker for the split isochronous back-pointer block
`timescale 1ns/1ns
module isb_backptr_asserts (
    input wire         I_REF_CLK,
    input wire         I_SYS_RST,
    input wire         I_VISIT_VLD,
    input wire         O_VISIT_RDY,
    input wire         O_VISIT_DONE,
    input wire [31:0]  O_NEXT_PTR,
    input wire [2:0]   I_FRINDEX,
    input wire         O_MEM_RD,
    input wire [31:0]  O_MEM_ADDR,
    input wire         I_MEM_RVLD,
    input wire [127:0] I_MEM_RDATA,
    input wire         O_SPLIT_REQ,
    input wire         O_SPLIT_CS,
    input wire [31:0]  O_SPLIT_DESC
);
    // ==================================================
    // Per-visit bookkeeping, restarted on every taken visit
    reg  [1:0]   rd_n_r;
    reg          rv_n_r;
    reg  [127:0] cur_r;
    wire         take     = I_VISIT_VLD && O_VISIT_RDY;
    wire         first_rv = I_MEM_RVLD && !rv_n_r;
    wire [7:0]   smask    = cur_r[71:64];
    wire [31:0]  back     = {cur_r[63:33], 1'b0};
    wire         want     = I_MEM_RDATA[95] && I_MEM_RDATA[89] &&
                            ((I_FRINDEX == 3'h0 && !I_MEM_RDATA[32]) || (I_FRINDEX == 3'h1 && !I_MEM_RDATA[64]));
    // Read count saturates at three so a runaway walk stays visible
    always @(posedge I_REF_CLK) begin
        if (I_SYS_RST || take) begin
            rd_n_r <= 2'h0;
            rv_n_r <= 1'b0;
        end else begin
            if (O_MEM_RD && rd_n_r != 2'h3)
                rd_n_r <= rd_n_r + 2'h1;
            if (first_rv) begin
                rv_n_r <= 1'b1;
                cur_r  <= I_MEM_RDATA;
            end
        end
    end
    // ==================================================
    // Properties
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_borrow_fetch: assert property (first_rv && want |-> ##[1:3] (O_MEM_RD && O_MEM_ADDR == back))
        else $error("back pointer fetch missing");
    a_no_borrow: assert property (first_rv && !I_MEM_RDATA[95] |-> ##1 !O_MEM_RD [*3])
        else $error("fetch after inactive descriptor");
    a_one_level: assert property (rd_n_r != 2'h3)
        else $error("back pointer followed twice");
    a_cs_context: assert property (O_SPLIT_REQ && O_SPLIT_CS && rd_n_r == 2'h2 |-> O_SPLIT_DESC == back)
        else $error("complete split with wrong context");
    a_start_slot: assert property (O_SPLIT_REQ && !O_SPLIT_CS |-> smask[I_FRINDEX])
        else $error("start split outside its slot");
    a_done_pulse: assert property (O_VISIT_DONE |=> !O_VISIT_DONE)
        else $error("done longer than one cycle");
    a_min_latency: assert property (take |=> !O_VISIT_DONE [*3])
        else $error("visit finished too early");
    a_next_ptr: assert property (O_VISIT_DONE |-> O_NEXT_PTR == cur_r[31:0])
        else $error("next pointer not from current");
    c_borrow: cover property (first_rv && want);
    c_cs_prev: cover property (O_SPLIT_REQ && O_SPLIT_CS && rd_n_r == 2'h2);
    c_start: cover property (O_SPLIT_REQ && !O_SPLIT_CS);
endmodule
bind isb_backptr isb_backptr_asserts chk_i (
    .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_VISIT_VLD(I_VISIT_VLD), .O_VISIT_RDY(O_VISIT_RDY),
    .O_VISIT_DONE(O_VISIT_DONE), .O_NEXT_PTR(O_NEXT_PTR), .I_FRINDEX(I_FRINDEX), .O_MEM_RD(O_MEM_RD),
    .O_MEM_ADDR(O_MEM_ADDR), .I_MEM_RVLD(I_MEM_RVLD), .I_MEM_RDATA(I_MEM_RDATA), .O_SPLIT_REQ(O_SPLIT_REQ),
    .O_SPLIT_CS(O_SPLIT_CS), .O_SPLIT_DESC(O_SPLIT_DESC));

// >>> isb_backptr_test.sv
// Self-checking bench for the split isochronous back-pointer block
`timescale 1ns/1ns
`include "isb_map.vh"
module isb_backptr_test;
    reg          clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, visit_vld = 1'b0;
    reg  [7:0]   reg_addr = 8'h00;
    reg  [31:0]  reg_wdata = 32'h0, visit_addr = 32'h0, sp_desc_r, v;
    reg  [2:0]   frindex = 3'h0, tt_rsp = 3'h0;
    reg          mem_rvld = 1'b0, tt_slow = 1'b0, sp_cs_r;
    reg  [7:0]   tt_bytes = 8'h00;
    reg  [127:0] mem_rdata = 128'h0, e;
    reg  [127:0] mem [0:15];
    wire [31:0]  rdata, next_ptr, mem_addr, split_desc;
    wire [127:0] mem_wdata;
    wire         rdy, done, mem_rd, mem_wr, split_req, split_cs, sp_done;
    wire [2:0]   sp_rsp;
    wire [7:0]   sp_bytes;
    integer      fail_count = 0, total_checks = 0, rd_cnt = 0, sp_cnt = 0, rd0, sp0, n;
    // ==================================================
    // Clock, design and translator
    always #2 clk = ~clk;
    isb_backptr uut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
        .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(rdata), .I_FRINDEX(frindex),
        .I_VISIT_VLD(visit_vld), .I_VISIT_ADDR(visit_addr), .O_VISIT_RDY(rdy), .O_VISIT_DONE(done),
        .O_NEXT_PTR(next_ptr), .O_MEM_RD(mem_rd), .O_MEM_WR(mem_wr), .O_MEM_ADDR(mem_addr),
        .I_MEM_RVLD(mem_rvld), .I_MEM_RDATA(mem_rdata), .O_MEM_WDATA(mem_wdata), .O_SPLIT_REQ(split_req),
        .O_SPLIT_CS(split_cs), .O_SPLIT_DESC(split_desc), .I_SPLIT_DONE(sp_done), .I_SPLIT_RESP(sp_rsp),
        .I_SPLIT_BYTES(sp_bytes));
    isb_tt_model tt (.i_clk(clk), .i_rst(rst), .i_req(split_req), .i_slow(tt_slow), .i_rsp(tt_rsp),
        .i_bytes(tt_bytes), .o_done(sp_done), .o_rsp(sp_rsp), .o_bytes(sp_bytes));
    // Descriptor memory answers one cycle after a read; data toggles when idle
    always @(posedge clk) begin
        mem_rvld <= mem_rd;
        mem_rdata <= mem_rd ? mem[mem_addr[7:4]] : ~mem_rdata;
        if (mem_wr)
            mem[mem_addr[7:4]] <= mem_wdata;
        if (mem_rd)
            rd_cnt <= rd_cnt + 1;
        if (split_req) begin
            sp_cnt <= sp_cnt + 1;
            sp_cs_r <= split_cs;
            sp_desc_r <= split_desc;
        end
    end
    // ==================================================
    // Helpers
    function [127:0] split_iso_descriptor(input [31:0] nx, bk, input [7:0] sm, cm, cp, input ph, act, input [9:0] tot);
        begin
            split_iso_descriptor = 128'h0;
            split_iso_descriptor[31:0] = nx;
            split_iso_descriptor[63:32] = bk;
            split_iso_descriptor[71:64] = sm;
            split_iso_descriptor[79:72] = cm;
            split_iso_descriptor[87:80] = cp;
            split_iso_descriptor[89] = ph;
            split_iso_descriptor[95] = act;
            split_iso_descriptor[105:96] = tot;
        end
    endfunction
    task chk(input [127:0] g, input [127:0] x);
        begin
            total_checks = total_checks + 1;
            if (g !== x) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    task rd_reg(input [7:0] a, output [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 d = rdata;
        end
    endtask
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    // One walker offer, held until taken, then a bounded wait for done
    task visit(input [31:0] a, input [2:0] uf);
        begin
            @(posedge clk);
            rd0 = rd_cnt;
            sp0 = sp_cnt;
            frindex <= uf;
            visit_addr <= a;
            visit_vld <= 1'b1;
            @(negedge clk);
            while (rdy !== 1'b1) @(negedge clk);
            @(posedge clk);
            visit_vld <= 1'b0;
            n = 0;
            while (done !== 1'b1 && n < 300) begin
                @(posedge clk);
                #1 n = n + 1;
            end
            if (n >= 300) chk(1'b0, 1'b1);
        end
    endtask
    task close_out;
        begin
            if (fail_count == 0 && total_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // ==================================================
    // Watchdog far beyond the hundred or fewer cycles the sequence needs
    initial begin
        #40000;
        fail_count = fail_count + 1;
        close_out;
    end
    // ==================================================
    // Main sequence
    initial begin
        mem[1] = split_iso_descriptor(32'h20, 32'h30, 8'h10, 8'hC3, 8'hC0, 1'b1, 1'b1, 10'd100);
        mem[2] = split_iso_descriptor(32'h40, 32'h10, 8'h10, 8'hC3, 8'h00, 1'b1, 1'b1, 10'd100);
        mem[3] = split_iso_descriptor(32'h50, 32'h01, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1, 10'd50);
        mem[5] = split_iso_descriptor(32'h60, 32'h30, 8'h01, 8'hC0, 8'h00, 1'b1, 1'b1, 10'd50);
        mem[6] = split_iso_descriptor(32'h70, 32'h10, 8'h10, 8'hC3, 8'h00, 1'b1, 1'b0, 10'd9);
        mem[7] = split_iso_descriptor(32'h80, 32'h01, 8'h10, 8'h06, 8'h00, 1'b1, 1'b1, 10'd10);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`ISB_REG_CTRL, v);
        chk(v, `ISB_CTRL_RST);
        wr_reg(8'hFC, 32'hFFFFFFFF);
        rd_reg(8'hFC, v);
        chk(v, 32'h0);
        // Inactive current at a wrap slot: no borrowing
        visit(32'h60, 3'h0);
        chk(rd_cnt - rd0, 1);
        chk(sp_cnt - sp0, 0);
        chk(next_ptr, 32'h70);
        // Micro-frame 0 borrow, partial data keeps the previous one active
        tt_rsp <= `ISB_RSP_MDAT;
        tt_bytes <= 8'd40;
        visit(32'h20, 3'h0);
        chk(rd_cnt - rd0, 2);
        chk({sp_cs_r, sp_desc_r}, {1'b1, 32'h10});
        e = split_iso_descriptor(32'h20, 32'h30, 8'h10, 8'hC3, 8'hC1, 1'b1, 1'b1, 10'd60);
        e[118:107] = 12'h028;
        chk(mem[1], e);
        chk(mem[2], split_iso_descriptor(32'h40, 32'h10, 8'h10, 8'hC3, 8'h00, 1'b1, 1'b1, 10'd100));
        chk(next_ptr, 32'h40);
        // Micro-frame 1 borrow with a slow translator, final data retires it
        tt_slow <= 1'b1;
        tt_rsp <= `ISB_RSP_DATA;
        tt_bytes <= 8'd60;
        visit(32'h20, 3'h1);
        e = split_iso_descriptor(32'h20, 32'h30, 8'h10, 8'hC3, 8'hC3, 1'b0, 1'b0, 10'd0);
        e[118:107] = 12'h064;
        chk(mem[1], e);
        chk(mem[2], split_iso_descriptor(32'h40, 32'h10, 8'h10, 8'hC3, 8'h00, 1'b0, 1'b1, 10'd100));
        chk(sp_cnt - sp0, 1);
        rd_reg(`ISB_REG_STATE, v);
        chk(v[10], 1'b1);
        // Previous still in start phase: missed, then immediate start split
        tt_slow <= 1'b0;
        tt_bytes <= 8'd0;
        @(posedge clk);
        frindex <= 3'h7;
        visit(32'h50, 3'h0);
        e = split_iso_descriptor(32'h50, 32'h01, 8'h01, 8'h00, 8'h00, 1'b0, 1'b0, 10'd50);
        e[90] = 1'b1;
        chk(mem[3], e);
        chk({sp_cs_r, sp_desc_r}, {1'b0, 32'h50});
        // Earlier complete-split slot skipped: missed and retired at once
        visit(32'h70, 3'h2);
        e = split_iso_descriptor(32'h80, 32'h01, 8'h10, 8'h06, 8'h00, 1'b1, 1'b0, 10'd10);
        e[90] = 1'b1;
        chk(mem[7], e);
        rd_reg(`ISB_REG_BORROW, v);
        chk(v, 32'h3);
        close_out;
    end
endmodule

// >>> isb_map.vh
// Constants for the split isochronous back-pointer completion block
`ifndef ISB_MAP_VH
`define ISB_MAP_VH
// ==========================================================
// Descriptor word layout (128-bit image)
`define ISB_F_NEXT   31:0
`define ISB_B_BACKT  32
`define ISB_F_BACK   63:32
`define ISB_F_SMASK  71:64
`define ISB_F_CMASK  79:72
`define ISB_F_CPROG  87:80
`define ISB_B_PHASE  89
`define ISB_B_MISSED 90
`define ISB_B_XERR   91
`define ISB_B_BABBLE 92
`define ISB_B_ERR    94
`define ISB_B_ACTIVE 95
`define ISB_F_TOTAL  105:96
`define ISB_B_PAGE   106
`define ISB_F_OFFSET 118:107
`define ISB_F_TPOS   120:119
`define ISB_F_TCOUNT 123:121
// ==========================================================
// Split phase values
`define ISB_PH_SS    1'b0
`define ISB_PH_CS    1'b1
// ==========================================================
// Translator answer codes
`define ISB_RSP_ERR  3'h0
`define ISB_RSP_XERR 3'h1
`define ISB_RSP_DATA 3'h2
`define ISB_RSP_NYET 3'h3
`define ISB_RSP_MDAT 3'h4
`define ISB_MAX_RETRY 2'h2
// ==========================================================
// Register offsets and reset values
`define ISB_REG_CTRL   8'h00
`define ISB_REG_STATE  8'h04
`define ISB_REG_BORROW 8'h08
`define ISB_CTRL_RST   1'b1
`endif

// >>> isb_tt_model.sv
// Behavioural transaction translator answering split requests
`timescale 1ns/1ns
module isb_tt_model (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_req,
    input  wire       i_slow,
    input  wire [2:0] i_rsp,
    input  wire [7:0] i_bytes,
    output reg        o_done,
    output reg  [2:0] o_rsp,
    output reg  [7:0] o_bytes
);
    reg       busy_r;
    reg [3:0] wait_r;
    // Answer lines toggle outside the done pulse so stale codes never look valid
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        o_rsp  <= ~o_rsp;
        o_bytes <= ~o_bytes;
        if (i_rst) begin
            busy_r  <= 1'b0;
            wait_r  <= 4'h0;
            o_rsp   <= 3'h0;
            o_bytes <= 8'h00;
        end else if (i_req) begin
            busy_r <= 1'b1;
            wait_r <= i_slow ? 4'h6 : 4'h0;
        end else if (busy_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (busy_r) begin
            busy_r  <= 1'b0;
            o_done  <= 1'b1;
            o_rsp   <= i_rsp;
            o_bytes <= i_bytes;
        end
    end
endmodule
